/* File: common/lcs_pkg.sv */
// display controller set-up package: register map, field positions, step and config types
// assumes the device answers one register access at a time on a simple word port
package lcs_pkg;

  // ****************************************************************
  // register byte offsets in the device
  // ****************************************************************
  localparam logic [11:0] ADDR_BASE_UPPER = 12'h000;
  localparam logic [11:0] ADDR_BASE_LOWER = 12'h004;
  localparam logic [11:0] ADDR_FETCH_CFG = 12'h018;
  localparam logic [11:0] ADDR_FETCH_CTRL = 12'h01c;
  localparam logic [11:0] ADDR_CTRL_1 = 12'h800;
  localparam logic [11:0] ADDR_CTRL_2 = 12'h804;
  localparam logic [11:0] ADDR_VERT_TIMING = 12'h808;
  localparam logic [11:0] ADDR_HORIZ_TIMING = 12'h80c;
  localparam logic [11:0] ADDR_PANEL_SIZE = 12'h810;
  localparam logic [11:0] ADDR_POWER_CTRL = 12'h83c;
  localparam logic [11:0] ADDR_CONTRAST_SETUP = 12'h840;
  localparam logic [11:0] ADDR_CONTRAST_LEVEL = 12'h844;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CLKDIV_LSB = 12;
  localparam int CLKDIV_W = 9;
  localparam int BYPASS_BIT = 0;
  localparam int VERT_FRONT_PORCH_LSB = 0;
  localparam int VERT_BACK_PORCH_LSB = 8;
  localparam int VSYNC_WIDTH_LSB = 16;
  localparam int VERT_TO_HORIZ_DELAY_LSB = 24;
  localparam int HORIZ_BACK_PORCH_LSB = 0;
  localparam int HSYNC_WIDTH_LSB = 8;
  localparam int HORIZ_FRONT_PORCH_LSB = 21;
  localparam int LINE_WIDTH_LSB = 21;
  localparam int LINE_COUNT_LSB = 0;
  localparam int BURST_LSB = 24;
  localparam int BURST_W = 7;
  localparam int FETCH_EN_BIT = 0;
  localparam int POWER_EN_BIT = 0;
  localparam int GUARD_LSB = 1;
  localparam int BUSY_BIT = 31;
  localparam int WORD_BITS_LOG2 = 5;
  localparam int FRAME_WORD_W = 23;

  localparam logic [BURST_W-1:0] BURST_4WORD = 7'h07;
  // least legal timing values; depend on the device build
  localparam logic [7:0] MIN_BACK_PORCH = 8'h00;
  localparam logic [12:0] MIN_SYNC_WIDTH = 13'h0000;
  localparam logic [7:0] MIN_VH_DELAY = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {OP_START = 2'h0, OP_STOP = 2'h1, OP_SWAP = 2'h2} lcs_op_t;
  typedef enum logic [2:0] {K_WR = 3'h0, K_POLL = 3'h1, K_EOF = 3'h2, K_SKIP = 3'h3,
                            K_END = 3'h4} lcs_kind_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_ACCESS = 2'b11,
                            ST_EOF = 2'b10} lcs_state_t;

  typedef struct packed {
    lcs_kind_t kind;
    logic [11:0] addr;
    logic [31:0] data;
  } lcs_step_t;

  typedef struct packed {
    logic [CLKDIV_W-1:0] clk_div;
    logic clk_bypass;
    logic [31:0] ctrl2;
    logic [7:0] vert_front_porch;
    logic [7:0] vert_back_porch;
    logic [7:0] vsync_width;
    logic [7:0] vert_to_horiz_delay;
    logic [7:0] horiz_back_porch;
    logic [12:0] hsync_width;
    logic [10:0] horiz_front_porch;
    logic [10:0] line_width;
    logic [10:0] line_count;
    logic [11:0] width_px;
    logic [11:0] height_px;
    logic [5:0] bpp;
    logic stn;
    logic dual;
    logic [6:0] guard;
    logic contrast_used;
    logic [31:0] contrast_setup;
    logic [31:0] contrast_level;
  } lcs_cfg_t;

endpackage : lcs_pkg

/* File: dv/lcs_dev_model.sv */
// device model: register file, core busy flag, frame fetch with end-of-frame, pixel clock
// assumes the controller's register port on the bench clock, used as the core clock
`timescale 1ns/100ps
module lcs_dev_model (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [11:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic REG_READY,
  output logic EOF_IRQ,
  output logic PIX_CLK,
  input wire logic SLOW,
  output logic ORDER_ERR
);
  // ****************************************************************
  // register file, access timing and frame state
  // ****************************************************************
  logic [31:0] regs [0:1023];
  logic [1:0] wait_cnt;
  logic [5:0] busy_cnt;
  logic [7:0] frame_cnt;
  logic [8:0] pix_cnt;
  logic pix_div;
  logic [31:0] shown_upper;
  logic [31:0] shown_lower;
  logic [31:0] noise;
  wire req = REG_WR | REG_RD;
  wire [9:0] idx = REG_ADDR[11:2];
  wire wr_now = REG_WR & REG_READY;
  wire powered = regs[10'h20f][0];
  wire fetching = powered & regs[10'h007][0];
  wire [31:0] pwr_read = {busy_cnt != 6'h00, regs[10'h20f][30:0]};
  assign REG_READY = req & (wait_cnt == (SLOW ? 2'h3 : 2'h0));
  // a released data bus shows a pattern that flips every cycle, never the last word
  assign REG_RDATA = REG_RD ? ((idx == 10'h20f) ? pwr_read : regs[idx]) : noise;
  assign EOF_IRQ = fetching & (frame_cnt < 8'h03);
  // bypass is not exercised: a core-rate clock cannot be seen through the sampler
  assign PIX_CLK = regs[10'h200][0] ? CLK : pix_div;
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int i = 0; i < 1024; i++)
        regs[i] <= 32'h0;
      regs[10'h200] <= 32'h00002000;
      regs[10'h20f] <= 32'h0000000e;
      regs[10'h207] <= 32'h000000a5;
      regs[10'h20e] <= 32'h0f5ffaff;
      busy_cnt <= 6'h0a;
      {wait_cnt, frame_cnt, pix_cnt, pix_div, ORDER_ERR} <= '0;
      {shown_upper, shown_lower, noise} <= '0;
    end
    else
    begin
      noise <= ~noise;
      wait_cnt <= (req & !REG_READY) ? wait_cnt + 2'h1 : 2'h0;
      busy_cnt <= (busy_cnt != 6'h00) ? busy_cnt - 6'h01 : 6'h00;
      if (wr_now)
        regs[idx] <= REG_WDATA;
      if (wr_now & idx == 10'h20f & REG_WDATA[0] & (!regs[7][0] | busy_cnt != 0))
        ORDER_ERR <= 1'b1;
      if (wr_now & idx == 10'h007 & !REG_WDATA[0] & powered)
        ORDER_ERR <= 1'b1;
      if (wr_now & idx == 10'h20f & !REG_WDATA[0] & powered)
        busy_cnt <= 6'h14;
      frame_cnt <= (!fetching | frame_cnt == 8'h00) ? 8'hc7 : frame_cnt - 8'h01;
      if (fetching & frame_cnt == 8'h00)
        {shown_upper, shown_lower} <= {regs[0], regs[1]};
      if (!powered)
        {pix_cnt, pix_div} <= '0;
      else if (pix_cnt == regs[10'h200][20:12])
        {pix_cnt, pix_div} <= {9'h000, ~pix_div};
      else
        pix_cnt <= pix_cnt + 9'h001;
    end
  end
endmodule : lcs_dev_model

/* File: dv/tb_top.sv */
// self-checking bench: random set-ups, start, swap, refusals and stop against the device model
// assumes the controller and the device model share the one 20 MHz clock
`timescale 1ns/100ps
module tb_top;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic clk;
  logic arst_n;
  logic start;
  logic stop;
  logic swap;
  logic slow;
  lcs_pkg::lcs_cfg_t cfg;
  logic [31:0] bu;
  logic [31:0] bl;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] old;
  logic [15:0] e0;
  logic [15:0] lo;
  logic [43:0] wlog[$];
  logic [43:0] exp_q[$];
  int fail_count;
  int tests_run;
  wire busy, done, core_on, reg_wr, reg_rd, reg_ready, eof, pix, order_err;
  wire [11:0] reg_addr;
  wire [31:0] reg_wdata;
  wire [31:0] reg_rdata;
  wire [15:0] pix_edges;
  lcs_host_ctrl DUT (.CLK(clk), .ARST_N(arst_n), .START(start), .STOP(stop), .SWAP(swap),
    .CFG(cfg), .BASE_UPPER(bu), .BASE_LOWER(bl), .BUSY(busy), .DONE(done), .CORE_ON(core_on),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .REG_READY(reg_ready), .EOF_IRQ(eof), .PIX_CLK(pix),
    .PIX_EDGES(pix_edges));
  lcs_dev_model DEV (.CLK(clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_READY(reg_ready),
    .EOF_IRQ(eof), .PIX_CLK(pix), .SLOW(slow), .ORDER_ERR(order_err));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
    if (reg_wr === 1'b1 && reg_ready === 1'b1)
      wlog.push_back({reg_addr, reg_wdata});
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [43:0] got, input logic [43:0] want);
    tests_run++;
    if (got !== want)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic push(input logic [11:0] a, input logic [31:0] d);
    exp_q.push_back({a, d});
  endtask : push
  task automatic check_log();
    chk(44'(wlog.size()), 44'(exp_q.size()));
    while (wlog.size() > 0 && exp_q.size() > 0)
      chk(wlog.pop_front(), exp_q.pop_front());
    wlog.delete();
    exp_q.delete();
  endtask : check_log
  // sel 1 waits on the end-of-frame line, sel 0 on the done pulse
  task automatic wait_for(input int sel, input logic v);
    for (int n = 0; n < 20000; n++)
    begin
      @(posedge clk);
      #1;
      if ((sel == 1 ? eof : done) === v)
        return;
    end
    fail_count++;
    $display("ERROR %0t: wait ran out", $time);
    report_and_stop();
  endtask : wait_for
  task automatic pulse(input int which, input logic expect_run);
    @(negedge clk);
    start = (which == 0);
    stop = (which == 1);
    swap = (which == 2);
    @(negedge clk);
    {start, stop, swap} = 3'b000;
    if (expect_run)
      wait_for(0, 1'b1);
    else
      chk(44'(busy), 44'h0);
  endtask : pulse
  task automatic make_cfg(input int i);
    logic [31:0] h;
    logic [31:0] w;
    @(negedge clk);
    r = rnd();
    cfg.clk_div = 9'(r[2:0]) + 9'h001;
    cfg.clk_bypass = 1'b0;
    slow = r[31];
    cfg.ctrl2 = rnd();
    {cfg.vert_front_porch, cfg.vert_back_porch, cfg.vsync_width,
     cfg.vert_to_horiz_delay} = rnd();
    {cfg.horiz_back_porch, cfg.hsync_width, cfg.horiz_front_porch} = rnd();
    r = rnd();
    {cfg.line_width, cfg.line_count, cfg.guard} = r[28:0];
    r = rnd();
    {cfg.width_px, cfg.height_px, cfg.bpp} = (i == 3) ? {12'hfff, 12'hfff, 6'h3f} : r[29:0];
    {cfg.stn, cfg.dual, cfg.contrast_used} = {i[0], i[1], i[0] ^ i[1]};
    cfg.contrast_setup = rnd();
    cfg.contrast_level = rnd();
    bu = rnd();
    bl = rnd();
    h = cfg.dual ? 32'(cfg.height_px) / 2 : 32'(cfg.height_px);
    w = 32'(cfg.width_px) * h * 32'(cfg.bpp) / 32;
    push(12'h800, {11'h0, cfg.clk_div, 11'h0, cfg.clk_bypass});
    push(12'h804, cfg.ctrl2);
    push(12'h808, cfg.stn ? 32'h0 : {cfg.vert_to_horiz_delay, cfg.vsync_width,
      cfg.vert_back_porch, cfg.vert_front_porch});
    push(12'h80c, {cfg.horiz_front_porch, cfg.stn ? 13'h0 : cfg.hsync_width,
      cfg.horiz_back_porch});
    push(12'h810, {cfg.line_width, 10'h0, cfg.line_count});
    if (cfg.contrast_used)
      push(12'h840, cfg.contrast_setup);
    if (cfg.contrast_used)
      push(12'h844, cfg.contrast_level);
    push(12'h000, bu);
    if (cfg.dual)
      push(12'h004, bl);
    push(12'h018, {1'b0, 7'h07, 1'b0, w[22:0]});
    push(12'h01c, 32'h1);
    push(12'h83c, {24'h0, cfg.guard, 1'b1});
  endtask : make_cfg
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    {arst_n, start, stop, swap, slow, bu, bl, cfg} = '0;
    seed = 32'hc77ae7fb;
    fail_count = 0;
    tests_run = 0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    pulse(2, 1'b0);
    pulse(1, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      make_cfg(i);
      pulse(0, 1'b1);
      check_log();
      chk(44'(core_on), 44'h1);
      chk(44'(order_err), 44'h0);
      e0 = pix_edges;
      repeat (400) @(posedge clk);
      #1;
      lo = 16'(200 / (cfg.clk_div + 9'h001)) - 16'h0001;
      chk(44'((pix_edges - e0) >= lo && (pix_edges - e0) <= lo + 16'h0002), 44'h1);
      pulse(0, 1'b0);
      old = DEV.shown_upper;
      bu = rnd();
      bl = rnd();
      push(12'h000, bu);
      if (cfg.dual)
        push(12'h004, bl);
      pulse(2, 1'b1);
      check_log();
      chk(44'(DEV.shown_upper), 44'(old));
      wait_for(1, 1'b0);
      wait_for(1, 1'b1);
      repeat (4) @(posedge clk);
      chk(44'(DEV.shown_upper), 44'(bu));
      if (cfg.dual)
        chk(44'(DEV.shown_lower), 44'(bl));
      push(12'h83c, {24'h0, cfg.guard, 1'b0});
      push(12'h01c, 32'h0);
      @(negedge clk);
      slow = ~slow;
      pulse(1, 1'b1);
      check_log();
      chk(44'(core_on), 44'h0);
      chk(44'(order_err), 44'h0);
    end
    report_and_stop();
  end
endmodule : tb_top

/* File: hw/lcs_host_ctrl.sv */
// host-side sequencer that starts, stops and double-buffers a display controller
// assumes the device register port answers on the same clock, one access at a time
//
// Function
// (R01) device fetches nothing before core power-on
// (R02) configure everything, enable fetch, then power
// (R03) first image ready before start order given
// (R04) shut down: power off first, fetch off after
// (R05) busy flag polled idle before power on
// (R06) pixel clock is core clock over divisor
// (R07) divisor field sits at bit twelve
// (R08) vertical timing fields at 0/8/16/24
// (R09) horizontal timing fields at 0/8/21
// (R10) stn zeros unused fields, respects minimums
// (R11) panel size: width at 21, lines at 0
// (R12) frame size in words, burst at 24
// (R13) four-word burst chosen
// (R14) single scan uses upper base only
// (R15) fetch enable written after full configuration
// (R16) power-on write is the final step
// (R17) dither patterns keep reset values
// (R18) base changes apply at next frame end
// (R19) dual bases both written within one frame
// (R20) contrast registers only with contrast line
// (R21) end-of-frame event marks base reload
// (R22) frame pointer counts words down
// (R23) bypass sends core clock straight out
// (R24) fetch reloads pointers every frame
`timescale 1ns/100ps
module lcs_host_ctrl (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic START,
  input wire logic STOP,
  input wire logic SWAP,
  input wire lcs_pkg::lcs_cfg_t CFG,
  input wire logic [31:0] BASE_UPPER,
  input wire logic [31:0] BASE_LOWER,
  output logic BUSY,
  output logic DONE,
  output logic CORE_ON,
  output logic [11:0] REG_ADDR,
  output logic [31:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic REG_READY,
  input wire logic EOF_IRQ,
  input wire logic PIX_CLK,
  output logic [15:0] PIX_EDGES
);

  // ****************************************************************
  // state
  // ****************************************************************
  lcs_pkg::lcs_state_t state;
  lcs_pkg::lcs_state_t next_state;
  lcs_pkg::lcs_op_t op;
  lcs_pkg::lcs_op_t next_op;
  lcs_pkg::lcs_kind_t kind;
  lcs_pkg::lcs_cfg_t cfg;
  lcs_pkg::lcs_step_t cur;
  logic [3:0] step;
  logic [3:0] next_step;
  logic [31:0] base_up;
  logic [31:0] base_lo;
  logic eof_s1, eof_s2, eof_s3;
  logic pix_s1, pix_s2, pix_s3;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      {eof_s1, eof_s2, eof_s3} <= 3'h0;
      {pix_s1, pix_s2, pix_s3} <= 3'h0;
      PIX_EDGES <= 16'h0000;
    end
    else
    begin
      {eof_s1, eof_s2, eof_s3} <= {EOF_IRQ, eof_s1, eof_s2};
      {pix_s1, pix_s2, pix_s3} <= {PIX_CLK, pix_s1, pix_s2};
      if (pix_s2 && !pix_s3)
        PIX_EDGES <= PIX_EDGES + 16'h0001;
    end
  end

  // rising edge of the end-of-frame line: the device reloads its bases on the clock edge that ends this one-cycle pulse
  wire eof_pulse = eof_s2 && !eof_s3; // R21 R24

  // ****************************************************************
  // register words
  // ****************************************************************
  // bypass and divisor travel together; the device picks between them
  wire [31:0] ctrl1_word = (32'(cfg.clk_div) << lcs_pkg::CLKDIV_LSB)
                         | (32'(cfg.clk_bypass) << lcs_pkg::BYPASS_BIT); // R06 R07 R23
  wire [7:0] bp_eff = (cfg.horiz_back_porch < lcs_pkg::MIN_BACK_PORCH)
                    ? lcs_pkg::MIN_BACK_PORCH : cfg.horiz_back_porch; // R10
  wire [12:0] sw_eff = cfg.stn ? 13'h0000 : (cfg.hsync_width < lcs_pkg::MIN_SYNC_WIDTH)
                     ? lcs_pkg::MIN_SYNC_WIDTH : cfg.hsync_width; // R10
  wire [7:0] delay_eff = (cfg.vert_to_horiz_delay < lcs_pkg::MIN_VH_DELAY)
                       ? lcs_pkg::MIN_VH_DELAY : cfg.vert_to_horiz_delay; // R10
  wire [31:0] vtim_full = (32'(cfg.vert_front_porch) << lcs_pkg::VERT_FRONT_PORCH_LSB)
                        | (32'(cfg.vert_back_porch) << lcs_pkg::VERT_BACK_PORCH_LSB)
                        | (32'(cfg.vsync_width) << lcs_pkg::VSYNC_WIDTH_LSB)
                        | (32'(delay_eff) << lcs_pkg::VERT_TO_HORIZ_DELAY_LSB); // R08
  wire [31:0] vtim_word = cfg.stn ? 32'h0000_0000 : vtim_full; // R10
  wire [31:0] htim_word = (32'(bp_eff) << lcs_pkg::HORIZ_BACK_PORCH_LSB)
                        | (32'(sw_eff) << lcs_pkg::HSYNC_WIDTH_LSB)
                        | (32'(cfg.horiz_front_porch) << lcs_pkg::HORIZ_FRONT_PORCH_LSB); // R09
  wire [31:0] panel_word = (32'(cfg.line_width) << lcs_pkg::LINE_WIDTH_LSB)
                         | (32'(cfg.line_count) << lcs_pkg::LINE_COUNT_LSB); // R11
  // dual scan: each panel holds half the lines
  wire [11:0] height_eff = cfg.dual ? (cfg.height_px >> 1) : cfg.height_px; // R12
  wire [29:0] frame_bits = 30'(cfg.width_px) * 30'(height_eff) * 30'(cfg.bpp);
  wire [lcs_pkg::FRAME_WORD_W-1:0] frame_words =
    frame_bits[lcs_pkg::WORD_BITS_LOG2 +: lcs_pkg::FRAME_WORD_W]; // R12
  wire [31:0] fetch_cfg_word = (32'(lcs_pkg::BURST_4WORD) << lcs_pkg::BURST_LSB)
                             | 32'(frame_words); // R12 R13
  wire [31:0] fetch_on_word = 32'h1 << lcs_pkg::FETCH_EN_BIT;
  wire [31:0] guard_word = 32'(cfg.guard) << lcs_pkg::GUARD_LSB;
  wire [31:0] power_on_word = guard_word | (32'h1 << lcs_pkg::POWER_EN_BIT);
  wire lo_kind_skip = !cfg.dual; // R14
  wire ct_kind_skip = !cfg.contrast_used; // R20

  // ****************************************************************
  // step tables; dither patterns are never touched (R17)
  // ****************************************************************
  always_comb
  begin
    cur = '{lcs_pkg::K_END, 12'h000, 32'h0000_0000};
    unique case (op)
      lcs_pkg::OP_START:
        unique case (step)
          4'h0: cur = '{lcs_pkg::K_POLL, lcs_pkg::ADDR_POWER_CTRL, 32'h0}; // R05
          4'h1: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_CTRL_1, ctrl1_word};
          4'h2: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_CTRL_2, cfg.ctrl2};
          4'h3: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_VERT_TIMING, vtim_word};
          4'h4: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_HORIZ_TIMING, htim_word};
          4'h5: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_PANEL_SIZE, panel_word};
          4'h6: cur = '{ct_kind_skip ? lcs_pkg::K_SKIP : lcs_pkg::K_WR,
                        lcs_pkg::ADDR_CONTRAST_SETUP, cfg.contrast_setup}; // R20
          4'h7: cur = '{ct_kind_skip ? lcs_pkg::K_SKIP : lcs_pkg::K_WR,
                        lcs_pkg::ADDR_CONTRAST_LEVEL, cfg.contrast_level}; // R20
          4'h8: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_BASE_UPPER, base_up};
          4'h9: cur = '{lo_kind_skip ? lcs_pkg::K_SKIP : lcs_pkg::K_WR,
                        lcs_pkg::ADDR_BASE_LOWER, base_lo}; // R14
          4'ha: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_FETCH_CFG, fetch_cfg_word};
          4'hb: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_FETCH_CTRL, fetch_on_word}; // R02 R15
          4'hc: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_POWER_CTRL, power_on_word}; // R01 R16
          default: cur = '{lcs_pkg::K_END, 12'h000, 32'h0};
        endcase
      lcs_pkg::OP_STOP:
        unique case (step)
          4'h0: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_POWER_CTRL, guard_word}; // R04
          4'h1: cur = '{lcs_pkg::K_POLL, lcs_pkg::ADDR_POWER_CTRL, 32'h0}; // R05
          4'h2: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_FETCH_CTRL, 32'h0}; // R04
          default: cur = '{lcs_pkg::K_END, 12'h000, 32'h0};
        endcase
      lcs_pkg::OP_SWAP:
        // writing right after frame end leaves a whole frame for both bases
        unique case (step)
          4'h0: cur = '{lcs_pkg::K_EOF, 12'h000, 32'h0}; // R19
          4'h1: cur = '{lcs_pkg::K_WR, lcs_pkg::ADDR_BASE_UPPER, base_up}; // R18
          4'h2: cur = '{lo_kind_skip ? lcs_pkg::K_SKIP : lcs_pkg::K_WR,
                        lcs_pkg::ADDR_BASE_LOWER, base_lo}; // R14 R19
          default: cur = '{lcs_pkg::K_END, 12'h000, 32'h0};
        endcase
      default: cur = '{lcs_pkg::K_END, 12'h000, 32'h0};
    endcase
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // orders are refused while busy, and only make sense in the matching core state
  wire go_stop = STOP && CORE_ON;
  wire go_swap = SWAP && CORE_ON && !go_stop;
  wire go_start = START && !CORE_ON && !STOP; // R03
  wire go_any = go_start || go_stop || go_swap;
  wire finish = (state == lcs_pkg::ST_ISSUE) && (cur.kind == lcs_pkg::K_END);
  wire still_busy = (kind == lcs_pkg::K_POLL) && REG_RDATA[lcs_pkg::BUSY_BIT]; // R05

  always_comb
  begin
    next_state = state;
    next_step = step;
    next_op = op;
    unique case (state)
      lcs_pkg::ST_IDLE:
        if (go_any)
        begin
          next_state = lcs_pkg::ST_ISSUE;
          next_step = 4'h0;
          next_op = go_stop ? lcs_pkg::OP_STOP : go_swap ? lcs_pkg::OP_SWAP : lcs_pkg::OP_START;
        end
      lcs_pkg::ST_ISSUE:
        unique case (cur.kind)
          lcs_pkg::K_END: next_state = lcs_pkg::ST_IDLE;
          lcs_pkg::K_SKIP: next_step = step + 4'h1;
          lcs_pkg::K_EOF: next_state = lcs_pkg::ST_EOF;
          lcs_pkg::K_WR, lcs_pkg::K_POLL: next_state = lcs_pkg::ST_ACCESS;
          default: next_state = lcs_pkg::ST_IDLE;
        endcase
      lcs_pkg::ST_ACCESS:
        if (REG_READY)
        begin
          next_state = lcs_pkg::ST_ISSUE;
          if (!still_busy)
            next_step = step + 4'h1;
        end
      lcs_pkg::ST_EOF:
        if (eof_pulse)
        begin
          next_state = lcs_pkg::ST_ISSUE;
          next_step = step + 4'h1;
        end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state <= lcs_pkg::ST_IDLE;
      step <= 4'h0;
      op <= lcs_pkg::OP_START;
      kind <= lcs_pkg::K_END;
      REG_ADDR <= 12'h000;
      REG_WDATA <= 32'h0000_0000;
      DONE <= 1'b0;
      CORE_ON <= 1'b0;
    end
    else
    begin
      state <= next_state;
      step <= next_step;
      op <= next_op;
      DONE <= finish;
      if (state == lcs_pkg::ST_ISSUE)
      begin
        kind <= cur.kind;
        REG_ADDR <= cur.addr;
        REG_WDATA <= cur.data;
      end
      if (finish)
        CORE_ON <= (op == lcs_pkg::OP_START) || (op == lcs_pkg::OP_SWAP);
    end
  end

  // settings and buffer addresses are frozen for the length of one order
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cfg <= '0;
      base_up <= 32'h0000_0000;
      base_lo <= 32'h0000_0000;
    end
    else if (state == lcs_pkg::ST_IDLE && go_any)
    begin
      if (go_start)
        cfg <= CFG;
      base_up <= BASE_UPPER;
      base_lo <= BASE_LOWER;
    end
  end

  assign BUSY = (state != lcs_pkg::ST_IDLE);
  assign REG_WR = (state == lcs_pkg::ST_ACCESS) && (kind == lcs_pkg::K_WR);
  assign REG_RD = (state == lcs_pkg::ST_ACCESS) && (kind == lcs_pkg::K_POLL);

  // ****************************************************************
  // checks
  // ****************************************************************
  logic fetch_on_done, power_off_done, idle_seen, eof_seen;
  wire wr_done = REG_WR && REG_READY;
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      {fetch_on_done, power_off_done, idle_seen, eof_seen} <= 4'h0;
    else if (state == lcs_pkg::ST_IDLE)
      {fetch_on_done, power_off_done, idle_seen, eof_seen} <= 4'h0;
    else
    begin
      if (wr_done && REG_ADDR == lcs_pkg::ADDR_FETCH_CTRL && REG_WDATA[lcs_pkg::FETCH_EN_BIT])
        fetch_on_done <= 1'b1;
      if (wr_done && REG_ADDR == lcs_pkg::ADDR_POWER_CTRL && !REG_WDATA[lcs_pkg::POWER_EN_BIT])
        power_off_done <= 1'b1;
      if (REG_RD && REG_READY && !REG_RDATA[lcs_pkg::BUSY_BIT])
        idle_seen <= 1'b1;
      if (state == lcs_pkg::ST_EOF && eof_pulse)
        eof_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  wire power_on_wr = REG_WR && REG_ADDR == lcs_pkg::ADDR_POWER_CTRL
                     && REG_WDATA[lcs_pkg::POWER_EN_BIT];

  power_last_a: assert property (power_on_wr |-> fetch_on_done) // R16
    else $error("core powered before fetch enabled");
  poll_idle_a: assert property (power_on_wr |-> idle_seen) // R05
    else $error("core powered without idle busy flag");
  stop_order_a: assert property (REG_WR && REG_ADDR == lcs_pkg::ADDR_FETCH_CTRL
    && !REG_WDATA[lcs_pkg::FETCH_EN_BIT] |-> power_off_done && idle_seen) // R04
    else $error("fetch disabled before core off");
  stn_zero_a: assert property (REG_WR && REG_ADDR == lcs_pkg::ADDR_VERT_TIMING && cfg.stn
    |-> REG_WDATA == 32'h0) // R10
    else $error("stn vertical timing not zero");
  single_base_a: assert property (REG_WR && REG_ADDR == lcs_pkg::ADDR_BASE_LOWER
    |-> cfg.dual) // R14
    else $error("lower base written in single scan");
  swap_eof_a: assert property (REG_WR && op == lcs_pkg::OP_SWAP |-> eof_seen) // R19
    else $error("swap base written before frame end");
  burst_field_a: assert property (REG_WR && REG_ADDR == lcs_pkg::ADDR_FETCH_CFG
    |-> REG_WDATA[lcs_pkg::BURST_LSB +: lcs_pkg::BURST_W] == lcs_pkg::BURST_4WORD) // R13
    else $error("burst length not four words");
  divisor_pos_a: assert property (REG_WR && REG_ADDR == lcs_pkg::ADDR_CTRL_1
    |-> REG_WDATA[lcs_pkg::CLKDIV_LSB +: lcs_pkg::CLKDIV_W] == cfg.clk_div) // R07
    else $error("divisor field misplaced");
  req_hold_a: assert property (REG_WR && !REG_READY |=> REG_WR && $stable(REG_ADDR)) // R15
    else $error("write request dropped early");
  eof_wake_a: assert property (state == lcs_pkg::ST_EOF && eof_pulse
    |=> state == lcs_pkg::ST_ISSUE ##1 REG_WR) // R18
    else $error("swap write not issued after frame end");

  start_cov: cover property (finish && op == lcs_pkg::OP_START);
  stop_cov: cover property (finish && op == lcs_pkg::OP_STOP);
  swap_cov: cover property (finish && op == lcs_pkg::OP_SWAP && cfg.dual);
  repoll_cov: cover property (REG_RD && REG_READY && still_busy);

endmodule : lcs_host_ctrl
